// >>> rtl/sdp_defines.svh
`ifndef SDP_DEFINES_SVH
`define SDP_DEFINES_SVH

// Register word addresses on the plain register port.
`define ADDR_FRAME_FORMAT   12'h126
`define ADDR_PIN_FUNCTION   12'h3fa
`define ADDR_RADIO_CTRL     12'h3f0
`define ADDR_STATUS         12'h3f1
`define ADDR_IRQ_SRC0       12'h3f2
`define ADDR_IRQ_SRC1       12'h3f3
`define ADDR_IRQ_MASK0      12'h3f4
`define ADDR_IRQ_MASK1      12'h3f5

// Field positions.
`define DATA_MODE_LSB       0
`define DATA_MODE_MSB       1
`define CTRL_STATE_LSB      0
`define CTRL_STATE_MSB      1
`define CTRL_SYNC_EN_BIT    2
`define SRC0_PREAMBLE_BIT   0
`define SRC0_SYNC_BIT       1
`define SRC1_CMD_DONE_BIT   0

// Reset values.
`define FRAME_FORMAT_RST    8'h00
`define PIN_FUNCTION_RST    8'h00
`define RADIO_CTRL_RST      8'h00
`define IRQ_MASK_RST        8'h00

// Pin function code range for serial port mode.
`define PIN_CODE_FIRST      8'ha0
`define PIN_CODE_LAST       8'ha8

// Highest bit index in one byte; the strobe spacing comes from the 3-bit counter, not from this.
`define BITS_PER_BYTE       3'h7

`endif

// >>> rtl/sdp_pkg.sv
package sdp_pkg;

	// Radio operating state as seen by this port.
	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_RX   = 2'b01,
		ST_TX   = 2'b10
	} radio_state_type;

	// Event pin behaviour selected by the pin function code.
	typedef enum logic [1:0]
	{
		EV_UNUSED = 2'b00,
		EV_LEVEL  = 2'b01,
		EV_STROBE = 2'b10
	} event_mode_type;

	// Register port request.
	typedef struct packed
	{
		logic [11:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} reg_req_type;

	// Demodulator side bits from the radio core.
	typedef struct packed
	{
		logic bit_valid;
		logic bit_data;
		logic preamble_det;
		logic sync_det;
	} demod_type;

endpackage : sdp_pkg

// >>> rtl/radio_serial_data_port.sv
// Operation
// - Data modes zero and three packet path, one and two serial
// - Mode one preamble event, two sync event
// - Codes A0/A3/A6 data and clock whole receive
// - Other codes: data after preamble only
// - Serial mode: receive out, transmit in
// - Transmit stream taken only from pin
// - Drive one bit clock per transmit bit
// - Keep sending until host leaves transmit
// - Receive clock follows recovered data bits
// - Level event stays active from trigger to end of receive state
// - Strobe one bit high every eight
// - Strobe aligned to trigger (preamble or sync), first bit
// - Host irq: full group1, group0 two flags
// - Sync detect optional, gives byte alignment
// - Pin code picks event type, pins
`include "sdp_defines.svh"

module radio_serial_data_port #(
	parameter int CLK_HZ = 20000000,
	parameter int BIT_HZ = 1000000
)(
	// Clock and reset.
	input  wire logic               clk,
	input  wire logic               srst,
	// Register port.
	input  wire sdp_pkg::reg_req_type reg_req,
	output logic [7:0]              reg_rdata,
	// Radio core side.
	input  wire sdp_pkg::demod_type demod,
	output logic                    mod_bit,
	output logic                    mod_bit_valid,
	output logic                    packet_path_en,
	input  wire logic               cmd_done_evt,
	// Serial port pins.
	output logic                    rx_data_pin_o,
	output logic                    rx_data_pin_oe,
	input  wire logic               tx_data_pin_i,
	output logic                    shared_bit_clock_pin_o,
	output logic                    shared_bit_clock_pin_oe,
	output logic                    rx_event_pin_o,
	output logic                    rx_event_pin_oe,
	output logic                    host_irq_pin
);

	localparam int HALF_BIT = (CLK_HZ / BIT_HZ / 2 < 1) ? 1 : CLK_HZ / BIT_HZ / 2;

	// Registers.
	logic [7:0]                frame_q;
	logic [7:0]                pinf_q;
	logic [7:0]                ctrl_q;
	logic [7:0]                src0_q;
	logic [7:0]                src1_q;
	logic [7:0]                mask0_q;
	logic [7:0]                mask1_q;
	logic [7:0]                rdata_q;
	// Serial engine state.
	logic [15:0]               div_q;
	logic                      clk_q;
	logic                      tx_bit_q;
	logic                      tx_vld_q;
	logic                      rx_bit_q;
	logic                      pre_seen_q;
	logic                      sync_seen_q;
	logic                      evt_level_q;
	logic                      strobe_q;
	logic [2:0]                bitcnt_q;
	logic [2:0]                tx_sync_q;
	logic                      pre_d1_q;
	logic                      sync_d1_q;

	// Decoded configuration.
	wire [1:0]                 data_mode = frame_q[`DATA_MODE_MSB:`DATA_MODE_LSB];
	wire                       serial_on = (data_mode == 2'h1) || (data_mode == 2'h2);
	wire                       code_ok = (pinf_q >= `PIN_CODE_FIRST) && (pinf_q <= `PIN_CODE_LAST);
	wire                       port_on = serial_on && code_ok;
	wire sdp_pkg::radio_state_type state = sdp_pkg::radio_state_type'(ctrl_q[`CTRL_STATE_MSB:`CTRL_STATE_LSB]);
	wire                       in_rx = port_on && (state == sdp_pkg::ST_RX);
	wire                       in_tx = port_on && (state == sdp_pkg::ST_TX);
	wire                       sync_en = ctrl_q[`CTRL_SYNC_EN_BIT];
	wire sdp_pkg::event_mode_type ev_mode = event_mode(pinf_q);
	wire                       data_early = (ev_mode == sdp_pkg::EV_UNUSED);

	// Codes step in threes: A0/A3/A6 unused, A1/A4/A7 level, A2/A5/A8 strobe.
	function automatic sdp_pkg::event_mode_type event_mode(input logic [7:0] code);
		logic [7:0] off;
		off = code - `PIN_CODE_FIRST;
		if (off % 8'h03 == 8'h00)
			event_mode = sdp_pkg::EV_UNUSED;
		else if (off % 8'h03 == 8'h01)
			event_mode = sdp_pkg::EV_LEVEL;
		else
			event_mode = sdp_pkg::EV_STROBE;
	endfunction : event_mode

	// Event selection: preamble in mode one, sync in mode two.
	wire                       pre_rise = demod.preamble_det && !pre_d1_q;
	wire                       sync_rise = demod.sync_det && !sync_d1_q && sync_en;
	wire                       ev_trigger = (data_mode == 2'h1) ? pre_rise : sync_rise;

	// Bit clock divider: rising edge at clk_q going high, falling at going low.
	wire                       div_hit = (div_q == 16'(HALF_BIT - 1));
	wire                       clk_run = in_tx;
	wire                       clk_rise = div_hit && !clk_q && clk_run;
	wire                       clk_fall = div_hit && clk_q;

	// Receive bits arrive from the recovered stream.
	wire                       rx_take = in_rx && demod.bit_valid;

	// Register write decode.
	wire                       wr_frame = reg_req.wr && (reg_req.addr == `ADDR_FRAME_FORMAT);
	wire                       wr_pinf = reg_req.wr && (reg_req.addr == `ADDR_PIN_FUNCTION);
	wire                       wr_ctrl = reg_req.wr && (reg_req.addr == `ADDR_RADIO_CTRL);
	wire                       wr_src0 = reg_req.wr && (reg_req.addr == `ADDR_IRQ_SRC0);
	wire                       wr_src1 = reg_req.wr && (reg_req.addr == `ADDR_IRQ_SRC1);
	wire                       wr_mask0 = reg_req.wr && (reg_req.addr == `ADDR_IRQ_MASK0);
	wire                       wr_mask1 = reg_req.wr && (reg_req.addr == `ADDR_IRQ_MASK1);

	// Read mux; unmapped addresses return zero.
	logic [7:0]                rd_mux;
	always_comb
	begin
		if (reg_req.addr == `ADDR_FRAME_FORMAT)
			rd_mux = frame_q;
		else if (reg_req.addr == `ADDR_PIN_FUNCTION)
			rd_mux = pinf_q;
		else if (reg_req.addr == `ADDR_RADIO_CTRL)
			rd_mux = ctrl_q;
		else if (reg_req.addr == `ADDR_STATUS)
			rd_mux = {3'h0, evt_level_q, sync_seen_q, pre_seen_q, ctrl_q[1:0]};
		else if (reg_req.addr == `ADDR_IRQ_SRC0)
			rd_mux = src0_q;
		else if (reg_req.addr == `ADDR_IRQ_SRC1)
			rd_mux = src1_q;
		else if (reg_req.addr == `ADDR_IRQ_MASK0)
			rd_mux = mask0_q;
		else if (reg_req.addr == `ADDR_IRQ_MASK1)
			rd_mux = mask1_q;
		else
			rd_mux = 8'h00;
	end

	// Configuration registers.
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			frame_q <= `FRAME_FORMAT_RST;
			pinf_q  <= `PIN_FUNCTION_RST;
			ctrl_q  <= `RADIO_CTRL_RST;
			mask0_q <= `IRQ_MASK_RST;
			mask1_q <= `IRQ_MASK_RST;
		end
		else
		begin
			if (wr_frame) frame_q <= reg_req.wdata;
			if (wr_pinf) pinf_q <= reg_req.wdata;
			if (wr_ctrl) ctrl_q <= reg_req.wdata;
			if (wr_mask0) mask0_q <= reg_req.wdata;
			if (wr_mask1) mask1_q <= reg_req.wdata;
		end
	end

	// Read data stands in the cycle after the strobe only.
	always_ff @(posedge clk)
	begin
		if (srst || !reg_req.rd)
			rdata_q <= 8'h00;
		else
			rdata_q <= rd_mux;
	end

	// Interrupt sources: write one to clear, a new event wins over the clear.
	wire [7:0]                 src0_set = {6'h00, demod.sync_det && !sync_d1_q, pre_rise};
	wire [7:0]                 src1_set = {7'h00, cmd_done_evt};
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			src0_q <= 8'h00;
			src1_q <= 8'h00;
		end
		else
		begin
			src0_q <= (src0_q & ~(wr_src0 ? reg_req.wdata : 8'h00)) | src0_set;
			src1_q <= (src1_q & ~(wr_src1 ? reg_req.wdata : 8'h00)) | src1_set;
		end
	end

	// In serial mode only the preamble and sync flags of group zero reach the pin.
	wire [7:0]                 grp0_allow = serial_on ? 8'h03 : 8'hff;
	wire                       irq_any = |(src0_q & mask0_q & grp0_allow) || |(src1_q & mask1_q);

	// Bit clock divider runs only in transmit. In receive the pin follows the recovered bits, so holding the
	// divider idle there means transmit always opens with a full low phase and never with a short high one.
	always_ff @(posedge clk)
	begin
		if (srst || !clk_run)
		begin
			div_q <= 16'h0000;
			clk_q <= 1'b0;
		end
		else if (div_hit)
		begin
			div_q <= 16'h0000;
			clk_q <= !clk_q;
		end
		else
			div_q <= div_q + 16'h0001;
	end

	// Transmit pin crosses into clk; three stages, second and third must agree.
	always_ff @(posedge clk)
	begin
		if (srst)
			tx_sync_q <= 3'h0;
		else
			tx_sync_q <= {tx_sync_q[1:0], tx_data_pin_i};
	end
	wire                       tx_pin_ok = (tx_sync_q[1] == tx_sync_q[2]);

	// Transmit sampling on the bit clock rising edge, one bit per clock.
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			tx_bit_q <= 1'b0;
			tx_vld_q <= 1'b0;
		end
		else
		begin
			tx_vld_q <= in_tx && clk_rise;
			if (in_tx && clk_rise)
				tx_bit_q <= tx_pin_ok ? tx_sync_q[2] : tx_bit_q;
		end
	end

	// Receive tracking: preamble and sync seen, byte counter for the strobe.
	always_ff @(posedge clk)
	begin
		if (srst || !in_rx)
		begin
			pre_seen_q  <= 1'b0;
			sync_seen_q <= 1'b0;
			evt_level_q <= 1'b0;
			bitcnt_q    <= 3'h0;
			rx_bit_q    <= 1'b0;
		end
		else
		begin
			if (pre_rise) pre_seen_q <= 1'b1;
			if (ev_trigger) evt_level_q <= 1'b1;
			if (ev_trigger)
			begin
				sync_seen_q <= 1'b1;
				bitcnt_q    <= 3'h0;
			end
			else if (rx_take)
				bitcnt_q <= bitcnt_q + 3'h1;
			if (rx_take) rx_bit_q <= demod.bit_data;
		end
	end

	// Strobe high for the first bit of each byte after the trigger.
	always_ff @(posedge clk)
	begin
		if (srst || !in_rx)
			strobe_q <= 1'b0;
		else if (rx_take)
			strobe_q <= sync_seen_q && (bitcnt_q == 3'h0);
	end

	// Edge history for the detector levels.
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			pre_d1_q  <= 1'b0;
			sync_d1_q <= 1'b0;
		end
		else
		begin
			pre_d1_q  <= demod.preamble_det;
			sync_d1_q <= demod.sync_det;
		end
	end

	// Pin drive. In receive the clock follows recovered bits, in transmit the divider.
	wire                       rx_data_en = in_rx && (data_early || pre_seen_q);
	assign reg_rdata               = rdata_q;
	assign packet_path_en          = !serial_on;
	assign mod_bit                 = tx_bit_q;
	assign mod_bit_valid           = tx_vld_q;
	assign rx_data_pin_o           = rx_bit_q;
	assign rx_data_pin_oe          = rx_data_en;
	assign shared_bit_clock_pin_o  = in_rx ? demod.bit_valid : clk_q;
	assign shared_bit_clock_pin_oe = port_on;
	assign rx_event_pin_o          = (ev_mode == sdp_pkg::EV_STROBE) ? strobe_q : evt_level_q;
	assign rx_event_pin_oe         = port_on && (ev_mode != sdp_pkg::EV_UNUSED);
	assign host_irq_pin            = irq_any;

endmodule : radio_serial_data_port

// >>> tb/radio_serial_data_port_monitor.sv
`include "sdp_defines.svh"

module sdp_checker #(
	parameter int CLK_HZ = 20000000,
	parameter int BIT_HZ = 1000000
)(
	// Clock and reset.
	input wire logic			clk,
	input wire logic			srst,
	// Register port.
	input wire sdp_pkg::reg_req_type	reg_req,
	input wire logic [7:0]		reg_rdata,
	// Radio core side.
	input wire sdp_pkg::demod_type	demod,
	input wire logic			mod_bit,
	input wire logic			mod_bit_valid,
	input wire logic			packet_path_en,
	input wire logic			cmd_done_evt,
	// Serial port pins.
	input wire logic			rx_data_pin_o,
	input wire logic			rx_data_pin_oe,
	input wire logic			tx_data_pin_i,
	input wire logic			shared_bit_clock_pin_o,
	input wire logic			shared_bit_clock_pin_oe,
	input wire logic			rx_event_pin_o,
	input wire logic			rx_event_pin_oe,
	input wire logic			host_irq_pin
);
	localparam int HALF = CLK_HZ / BIT_HZ / 2;
	logic [1:0]	mode_q;
	logic [1:0]	st_q;
	logic [7:0]	code_q;
	logic [7:0]	hi_q;
	// Decoded view of the shadow registers.
	wire logic act = (mode_q == 2'h1 || mode_q == 2'h2) && code_q >= `PIN_CODE_FIRST && code_q <= `PIN_CODE_LAST;
	wire logic rx = act && st_q == 2'h1;
	wire logic tx = act && st_q == 2'h2;
	wire logic full = code_q == 8'ha0 || code_q == 8'ha3 || code_q == 8'ha6;
	wire logic lvl = code_q == 8'ha1 || code_q == 8'ha4 || code_q == 8'ha7;

	// Shadows follow the writes on the port, so no path into the design's body is needed.
	always_ff @(posedge clk)
	begin
		hi_q <= (shared_bit_clock_pin_o && tx) ? hi_q + 8'h01 : 8'h00;
		if (srst)
		begin
			mode_q <= 2'h0;
			st_q <= 2'h0;
			code_q <= 8'h00;
		end
		else if (reg_req.wr)
		begin
			if (reg_req.addr == `ADDR_FRAME_FORMAT) mode_q <= reg_req.wdata[1:0];
			if (reg_req.addr == `ADDR_PIN_FUNCTION) code_q <= reg_req.wdata;
			if (reg_req.addr == `ADDR_RADIO_CTRL) st_q <= reg_req.wdata[1:0];
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	chk_path_mode: assert property (packet_path_en == (mode_q == 2'h0 || mode_q == 2'h3))
		else $error("Packet path enable disagrees with data mode.");
	chk_rx_clock: assert property (rx && $past(rx) |-> shared_bit_clock_pin_oe && shared_bit_clock_pin_o == demod.bit_valid)
		else $error("Receive bit clock does not follow recovered bits.");
	chk_rx_data: assert property (rx && demod.bit_valid |=> !rx_data_pin_oe || rx_data_pin_o == $past(demod.bit_data))
		else $error("Receive pin shows a wrong bit.");
	chk_rx_whole: assert property (rx && $past(rx) && full |-> rx_data_pin_oe)
		else $error("Receive data not enabled for whole receive state.");
	chk_tx_sample: assert property (mod_bit_valid |-> mod_bit == $past(tx_data_pin_i, 4))
		else $error("Transmit bit not taken from the pin.");
	chk_tx_take: assert property ($rose(shared_bit_clock_pin_o) && tx |-> mod_bit_valid)
		else $error("Transmit clock rise without a bit taken.");
	chk_clk_half: assert property ($fell(shared_bit_clock_pin_o) && tx && hi_q != 8'h00 |-> hi_q == HALF)
		else $error("Transmit clock high phase has wrong length.");
	chk_ev_unused: assert property (act && full && $past(full) |-> !rx_event_pin_oe)
		else $error("Event pin driven for an unused code.");
	chk_ev_hold: assert property (rx && lvl && rx_event_pin_o |=> rx_event_pin_o || !rx)
		else $error("Event level dropped inside receive state.");
endmodule : sdp_checker

bind radio_serial_data_port sdp_checker #(.CLK_HZ(CLK_HZ), .BIT_HZ(BIT_HZ)) chk_u (.*);

// >>> tb/sdp_host_model.sv
module sdp_host_model (
	// Clock and the device's bit clock.
	input wire logic		clk,
	input wire logic		bclk,
	input wire logic		bclk_oe,
	// Frame request from the bench.
	input wire logic		go,
	input wire logic [15:0]	pat,
	// Transmit pin and the note of each bit sent.
	output logic			tx_pin = 1'b0,
	output logic			note_bit = 1'b0,
	output logic			note_stb = 1'b0
);
	timeunit 1ns;
	timeprecision 1ns;
	logic		bclk_q = 1'b0;
	logic [4:0]	left_q = 5'h10;

	// Bits change just after a falling edge, so each stands still around the rising edge.
	always @(posedge clk)
	begin
		bclk_q <= bclk;
		note_stb <= 1'b0;
		if (!go) left_q <= 5'h10;
		if (!bclk_oe) tx_pin <= ~tx_pin; // Clock released: the pin carries junk.
		else if (go && bclk_q && !bclk && left_q != 5'h00)
		begin
			tx_pin <= pat[left_q[3:0] - 4'h1];
			note_bit <= pat[left_q[3:0] - 4'h1];
			note_stb <= 1'b1;
			left_q <= left_q - 5'h01;
		end
	end
endmodule : sdp_host_model

// >>> tb/radio_serial_data_port_tb_top.sv
`include "sdp_defines.svh"

module radio_serial_data_port_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic			clk = 1'b0;
	logic			srst = 1'b1;
	sdp_pkg::reg_req_type	reg_req = '0;
	sdp_pkg::demod_type	demod = '0;
	logic			cmd_done_evt = 1'b0;
	logic			go = 1'b0;
	logic [16:0]		lf = 17'h18490;
	logic [7:0]		reg_rdata;
	logic			mod_bit, mod_bit_valid, packet_path_en, rx_data_pin_o, rx_data_pin_oe, tx_data_pin_i;
	logic			shared_bit_clock_pin_o, shared_bit_clock_pin_oe, rx_event_pin_o, rx_event_pin_oe;
	logic			host_irq_pin, nbit, nstb;
	logic			rd_d = 1'b0;
	logic			bv_d = 1'b0;
	int			fail_count = 0;
	int			cmp_count = 0;
	logic [7:0]		rq[$];
	logic			bq[$];
	logic			tq[$];

	// Bench clock at 20 MHz.
	always #25 clk = ~clk;

	radio_serial_data_port dut_u (
		.clk(clk), .srst(srst), .reg_req(reg_req), .reg_rdata(reg_rdata), .demod(demod), .mod_bit(mod_bit),
		.mod_bit_valid(mod_bit_valid), .packet_path_en(packet_path_en), .cmd_done_evt(cmd_done_evt),
		.rx_data_pin_o(rx_data_pin_o), .rx_data_pin_oe(rx_data_pin_oe), .tx_data_pin_i(tx_data_pin_i),
		.shared_bit_clock_pin_o(shared_bit_clock_pin_o), .shared_bit_clock_pin_oe(shared_bit_clock_pin_oe),
		.rx_event_pin_o(rx_event_pin_o), .rx_event_pin_oe(rx_event_pin_oe), .host_irq_pin(host_irq_pin));
	sdp_host_model host_u (.clk(clk), .bclk(shared_bit_clock_pin_o), .bclk_oe(shared_bit_clock_pin_oe), .go(go),
		.pat(lf[15:0]), .tx_pin(tx_data_pin_i), .note_bit(nbit), .note_stb(nstb));

	function automatic logic [16:0] lfsr_next(input logic [16:0] s);
		return {s[15:0], s[16] ^ s[13]};
	endfunction : lfsr_next

	task automatic check_eq(input string what, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check_eq

	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : finish_test

	// One register cycle; a read notes its expected answer.
	task automatic reg_acc(input logic r, input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_req <= '{a, d, !r, r};
		if (r) rq.push_back(d);
		@(posedge clk);
		reg_req <= '0;
	endtask : reg_acc

	// One recovered bit every 8 cycles, the 400 ns link rate.
	task automatic send_bit();
		repeat (5) @(posedge clk);
		demod.bit_valid <= 1'b1;
		demod.bit_data <= lf[0];
		bq.push_back(lf[0]);
		lf <= lfsr_next(lf);
		@(posedge clk);
		demod.bit_valid <= 1'b0;
		repeat (2) @(posedge clk);
	endtask : send_bit

	// Results as they appear, matched against the oldest note.
	always @(posedge clk)
	begin
		rd_d <= reg_req.rd;
		bv_d <= demod.bit_valid;
		if (rd_d) check_eq("read data", reg_rdata, rq.pop_front());
		if (bv_d && rx_data_pin_oe) check_eq("receive bit", rx_data_pin_o, bq.pop_front());
		else if (bv_d) void'(bq.pop_front());
		if (mod_bit_valid && tq.size() > 0) check_eq("transmit bit", mod_bit, tq.pop_front());
		if (nstb) tq.push_back(nbit);
	end

	// Main sequence.
	initial
	begin
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		reg_acc(1'b1, `ADDR_FRAME_FORMAT, `FRAME_FORMAT_RST);
		reg_acc(1'b1, `ADDR_PIN_FUNCTION, `PIN_FUNCTION_RST);
		reg_acc(1'b1, 12'h001, 8'h00);
		reg_acc(1'b0, `ADDR_IRQ_MASK0, lf[7:0]);
		reg_acc(1'b1, `ADDR_IRQ_MASK0, lf[7:0]);
		reg_acc(1'b0, `ADDR_IRQ_MASK0, 8'h00);
		for (int c = 8'ha0; c <= 8'ha8; c++)
		begin
			reg_acc(1'b0, `ADDR_FRAME_FORMAT, 8'h01);
			reg_acc(1'b0, `ADDR_PIN_FUNCTION, 8'(c));
			reg_acc(1'b0, `ADDR_RADIO_CTRL, 8'h01);
			repeat (2) send_bit();
			check_eq("early data enable", rx_data_pin_oe, c % 3 == 1);
			demod.preamble_det <= 1'b1;
			repeat (2) send_bit();
			check_eq("late data enable", rx_data_pin_oe, 1'b1);
			check_eq("event enable", rx_event_pin_oe, c % 3 != 1);
			check_eq("event level", rx_event_pin_o, c % 3 != 0);
			demod.preamble_det <= 1'b0;
			reg_acc(1'b0, `ADDR_RADIO_CTRL, 8'h00);
		end
		reg_acc(1'b0, `ADDR_FRAME_FORMAT, 8'h02);
		reg_acc(1'b0, `ADDR_PIN_FUNCTION, 8'ha5);
		// Mode two ignores the preamble, and a sync word is ignored while sync detection is off.
		reg_acc(1'b0, `ADDR_RADIO_CTRL, 8'h01);
		demod.preamble_det <= 1'b1;
		demod.sync_det <= 1'b1;
		repeat (2) send_bit();
		check_eq("event on preamble", rx_event_pin_o, 1'b0);
		demod.sync_det <= 1'b0;
		reg_acc(1'b0, `ADDR_RADIO_CTRL, 8'h05);
		demod.sync_det <= 1'b1;
		for (int k = 0; k < 17; k++)
		begin
			send_bit();
			check_eq("byte strobe", rx_event_pin_o, k % 8 == 0);
		end
		demod <= '0;
		reg_acc(1'b0, `ADDR_FRAME_FORMAT, 8'h01);
		reg_acc(1'b0, `ADDR_IRQ_MASK1, 8'h01);
		reg_acc(1'b0, `ADDR_RADIO_CTRL, 8'h02);
		cmd_done_evt <= 1'b1;
		@(posedge clk);
		cmd_done_evt <= 1'b0;
		repeat (2) @(posedge clk);
		check_eq("host interrupt", host_irq_pin, 1'b1);
		go <= 1'b1;
		repeat (16 * 20 + 60) @(posedge clk);
		reg_acc(1'b0, `ADDR_RADIO_CTRL, 8'h00);
		go <= 1'b0;
		check_eq("transmit notes left", 8'(tq.size()), 8'h00);
		reg_acc(1'b0, `ADDR_IRQ_SRC1, 8'h01);
		@(posedge clk);
		check_eq("host interrupt cleared", host_irq_pin, 1'b0);
		finish_test();
	end

	// Cuts a hung run short; the sequence needs about a sixth of this span.
	initial
	begin
		repeat (6000) @(posedge clk);
		fail_count++;
		finish_test();
	end
endmodule : radio_serial_data_port_tb_top
